// *** core/mda_defines.svh ***
// Purpose: Offsets, field positions, codes and timing for the memory attribute block
// Assumes: 16-bit configuration words at byte offsets in A16 space
// Notes: Included by bare name from the modules
`ifndef MDA_DEFINES_SVH
`define MDA_DEFINES_SVH

// A16 configuration register byte offsets
`define MDA_OFS_ID 6'h00
`define MDA_OFS_DEVTYPE 6'h02
`define MDA_OFS_STATCTL 6'h04
`define MDA_OFS_OFFSET 6'h06
`define MDA_OFS_ATTR 6'h08
`define MDA_OFS_SCRATCH 6'h0A

// A16 configuration area placement and register reset values
`define MDA_A16_TOP 2'h3
`define MDA_OFFSET_RST 16'h0000
`define MDA_SCRATCH_RST 16'h0000

// Attribute field positions
`define MDA_ATTR_KIND_HI 15
`define MDA_ATTR_NS 13
`define MDA_ATTR_BLOCK_XFER 12
`define MDA_ATTR_NP 11
`define MDA_ATTR_WORD32 7
`define MDA_ATTR_WORD64 6
`define MDA_ATTR_RSV 2'h3

// Memory kind codes
`define MDA_KIND_RAM 2'h3
`define MDA_KIND_ROM 2'h1
`define MDA_KIND_OTHER 2'h2

// Control field positions
`define MDA_CTL_MEM_EN 15
`define MDA_CTL_SRST 0

// Address modifier codes accepted for single D16 cycles
`define MDA_AM_A16_SUP 6'h2D
`define MDA_AM_A16_USR 6'h29
`define MDA_AM_A24_SUP 6'h3D
`define MDA_AM_A24_USR 6'h39
`define MDA_AM_A32_SUP 6'h0D
`define MDA_AM_A32_USR 6'h09
`define MDA_AM_A64_SGL 6'h01

// Timing: clock period and upper edge of the default speed class
`define MDA_CLK_NS 40
`define MDA_CLASS_MAX_NS 800
`define MDA_CLASS_MAX_CYC (`MDA_CLASS_MAX_NS / `MDA_CLK_NS)
`define MDA_SYNC_CYC 2

`endif

// *** core/mda_pkg.sv ***
// Purpose: Types for the memory attribute block
// Assumes: Constants live in mda_defines.svh
// Notes: Address space codes are the ID register field values
package mda_pkg;
    // Bus cycle state
    typedef enum logic [1:0] {
        MDA_ST_IDLE,
        MDA_ST_WAIT,
        MDA_ST_ACK,
        MDA_ST_HOLD
    } mda_state_t;

    // Space holding the memory block
    typedef enum logic [1:0] {
        MDA_SP_A24,
        MDA_SP_A32,
        MDA_SP_A64,
        MDA_SP_A16_ONLY
    } mda_space_t;
endpackage

// *** core/mda_mem_window.sv ***
// Purpose: Decode the memory block window in A24, A32 or A64 space
// Assumes: Address and modifier already synchronised
// Notes: Block base is the offset register in the top 16 bits of the space
`timescale 1ns/100ps
`include "mda_defines.svh"
module mda_mem_window #(
    parameter mda_pkg::mda_space_t SPACE = mda_pkg::MDA_SP_A24,
    parameter int MEM_AW = 8
) (
    // Bus cycle fields
    input wire logic [63:0] addr_i,
    input wire logic [5:0] am_i,
    // Configuration state
    input wire logic [15:0] offset_i,
    input wire logic mem_en_i,
    input wire logic ns_both_i,
    // Decode result
    output logic hit_o,
    output logic [MEM_AW-1:0] index_o
);
    import mda_pkg::*;

    logic base_match;
    logic am_sup;
    logic am_usr;

    // Space selection and base compare
    always_comb
    begin
        base_match = 1'b0;
        am_sup = 1'b0;
        am_usr = 1'b0;
        case (SPACE)
            MDA_SP_A24:
            begin
                base_match = (addr_i[23:8] == offset_i);
                am_sup = (am_i == `MDA_AM_A24_SUP);
                am_usr = (am_i == `MDA_AM_A24_USR);
            end
            MDA_SP_A32:
            begin
                base_match = (addr_i[31:16] == offset_i);
                am_sup = (am_i == `MDA_AM_A32_SUP);
                am_usr = (am_i == `MDA_AM_A32_USR);
            end
            MDA_SP_A64:
            begin
                base_match = (addr_i[63:48] == offset_i);
                am_sup = (am_i == `MDA_AM_A64_SGL);
            end
            default:
            begin
                base_match = 1'b0;
            end
        endcase
    end

    assign hit_o = mem_en_i && base_match && (am_sup || (am_usr && ns_both_i));
    assign index_o = addr_i[MEM_AW:1];
endmodule

// *** core/mda_attr_regs.sv ***
// Purpose: Memory device configuration slave with attribute register and memory block
// Assumes: Backplane pins arrive asynchronously; D16 single cycles only
// Notes: No answer is given to unclaimed cycles; the bus times them out
//
// Operation
// - Top two attribute bits give memory kind: RAM, ROM or other.
// - Bit 13 set means user and supervisory access; clear means supervisory only.
// - Bit 12 low means block transfers supported; high otherwise.
// - Bit 11 low means non-volatile RAM or electrically programmable ROM.
// - Bits 10 to 8 give the access speed class code.
// - Strobe to acknowledge delay stays within the reported speed class.
// - Bit 7 low means 32-bit transfers accepted besides narrower ones.
// - Bit 6 low means 64-bit transfers accepted besides narrower ones.
// - Bits 5 and 4 always read as ones.
// - Low four bits hold a fixed device-specific value.
// - Attribute register is read-only; writes complete without effect.
// - Memory decoded as one block in wide space at offset register base.
// - Memory block never placed in 16-bit-only address space.
// - Standard configuration registers plus attribute register in A16 space.
// - Spare A16 locations may hold device-specific functions.
`timescale 1ns/100ps
`include "mda_defines.svh"
module mda_attr_regs #(
    parameter logic [1:0] MEM_KIND = `MDA_KIND_RAM,
    parameter logic NS_BOTH = 1'b1,
    parameter logic NP_N = 1'b1,
    parameter logic [2:0] SPEED_CLASS = 3'h4,
    parameter logic [3:0] DEV_DEP = 4'h0,
    parameter logic [11:0] MAKER_ID = 12'hABC, // Arbitrary value
    parameter logic [15:0] DEV_TYPE = 16'h1357, // Arbitrary value
    parameter logic [1:0] ID_CLASS = 2'h1, // Arbitrary value
    parameter mda_pkg::mda_space_t SPACE = mda_pkg::MDA_SP_A24,
    parameter int MEM_AW = 8,
    parameter logic [4:0] MEM_WAIT = 5'h04
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Logical address strap
    input wire logic [7:0] la_i,
    // Backplane address and control
    input wire logic [63:0] addr_i,
    input wire logic [5:0] am_i,
    input wire logic as_n_i,
    input wire logic ds0_n_i,
    input wire logic ds1_n_i,
    input wire logic write_n_i,
    // Backplane data, two-way
    input wire logic [15:0] data_i,
    output logic [15:0] data_o,
    output logic data_oe_o,
    // Acknowledge, open drain
    output logic dtack_n_o,
    output logic dtack_oe_o,
    // Status
    output logic mem_en_o
);
    import mda_pkg::*;

    localparam int SYNC_W = 64 + 6 + 4 + 16 + 8;
    // Data path is 16 bits, single cycles only
    localparam logic BLOCK_XFER_CAPABLE_N = 1'b1;
    localparam logic WORD32_CAPABLE_N = 1'b1;
    localparam logic WORD64_CAPABLE_N = 1'b1;
    localparam logic [4:0] WAIT_MAX = 5'(`MDA_CLASS_MAX_CYC - `MDA_SYNC_CYC - 2);

    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [63:0] a_s;
    logic [5:0] am_s;
    logic as_s;
    logic ds0_s;
    logic ds1_s;
    logic wr_s;
    logic [15:0] d_s;
    logic [7:0] la_s;
    logic [1:0] boot_q;
    logic [7:0] la_q;
    mda_state_t state_q;
    logic [4:0] wait_q;
    logic cfg_sel_q;
    logic mem_sel_q;
    logic [15:0] offset_q;
    logic mem_en_q;
    logic srst_q;
    logic [15:0] scratch_q;
    logic [15:0] attr;
    logic [15:0] id_word;
    logic [15:0] cfg_rdata;
    logic cfg_hit;
    logic mem_hit;
    logic [MEM_AW-1:0] mem_idx;
    logic [MEM_AW-1:0] idx_q;
    logic strobe;
    logic done;
    logic [15:0] mem_q [0:(1 << MEM_AW)-1];

    // Two-stage synchroniser for every pin
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync1_q <= '1;
            sync2_q <= '1;
        end
        else
        begin
            sync1_q <= {addr_i, am_i, as_n_i, ds0_n_i, ds1_n_i, write_n_i, data_i, la_i};
            sync2_q <= sync1_q;
        end
    end

    // Synchronised fields, strobes turned active high
    assign a_s = sync2_q[SYNC_W-1 -: 64];
    assign am_s = sync2_q[SYNC_W-65 -: 6];
    assign as_s = !sync2_q[27];
    assign ds0_s = !sync2_q[26];
    assign ds1_s = !sync2_q[25];
    assign wr_s = !sync2_q[24];
    assign d_s = sync2_q[23:8];
    assign la_s = sync2_q[7:0];
    assign strobe = as_s && (ds0_s || ds1_s);

    // Strap capture once the synchroniser has filled
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            boot_q <= 2'h0;
            la_q <= 8'h00;
        end
        else if (boot_q != 2'h3)
        begin
            boot_q <= boot_q + 2'h1;
            la_q <= la_s;
        end
    end

    assign attr = {MEM_KIND, NS_BOTH, BLOCK_XFER_CAPABLE_N, NP_N, SPEED_CLASS,
                   WORD32_CAPABLE_N, WORD64_CAPABLE_N, `MDA_ATTR_RSV, DEV_DEP};
    assign id_word = {ID_CLASS, 2'(SPACE), MAKER_ID};

    assign cfg_hit = (a_s[15:14] == `MDA_A16_TOP) && (a_s[13:6] == la_q)
        && ((am_s == `MDA_AM_A16_SUP) || (am_s == `MDA_AM_A16_USR));

    // Memory block window
    mda_mem_window #(
        .SPACE(SPACE),
        .MEM_AW(MEM_AW)
    ) u_window (
        .addr_i(a_s),
        .am_i(am_s),
        .offset_i(offset_q),
        .mem_en_i(mem_en_q),
        .ns_both_i(NS_BOTH),
        .hit_o(mem_hit),
        .index_o(mem_idx)
    );

    // Configuration read mux
    always_comb
    begin
        if (a_s[5:0] == `MDA_OFS_ID)
            cfg_rdata = id_word;
        else if (a_s[5:0] == `MDA_OFS_DEVTYPE)
            cfg_rdata = DEV_TYPE;
        else if (a_s[5:0] == `MDA_OFS_STATCTL)
            cfg_rdata = {mem_en_q, 14'h3FFF, srst_q};
        else if (a_s[5:0] == `MDA_OFS_OFFSET)
            cfg_rdata = offset_q;
        else if (a_s[5:0] == `MDA_OFS_ATTR)
            cfg_rdata = attr;
        else if (a_s[5:0] == `MDA_OFS_SCRATCH)
            cfg_rdata = scratch_q;
        else
            cfg_rdata = 16'h0000;
    end

    // Cycle sequencer
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= MDA_ST_IDLE;
            wait_q <= 5'h00;
            cfg_sel_q <= 1'b0;
            mem_sel_q <= 1'b0;
            idx_q <= '0;
        end
        else
        begin
            case (state_q)
                MDA_ST_IDLE:
                begin
                    if (strobe)
                    begin
                        cfg_sel_q <= cfg_hit;
                        mem_sel_q <= mem_hit && !cfg_hit;
                        idx_q <= mem_idx;
                        wait_q <= 5'h00;
                        state_q <= (cfg_hit || mem_hit) ? MDA_ST_WAIT : MDA_ST_HOLD;
                    end
                end
                MDA_ST_WAIT:
                begin
                    if (wait_q >= MEM_WAIT || wait_q >= WAIT_MAX || cfg_sel_q)
                        state_q <= MDA_ST_ACK;
                    else
                        wait_q <= wait_q + 5'h01;
                end
                MDA_ST_ACK:
                begin
                    if (!strobe)
                        state_q <= MDA_ST_IDLE;
                end
                default:
                begin
                    if (!strobe)
                        state_q <= MDA_ST_IDLE;
                end
            endcase
        end
    end

    assign done = (state_q == MDA_ST_WAIT)
        && (wait_q >= MEM_WAIT || wait_q >= WAIT_MAX || cfg_sel_q);

    // Configuration register writes
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            offset_q <= `MDA_OFFSET_RST;
            mem_en_q <= 1'b0;
            srst_q <= 1'b0;
            scratch_q <= `MDA_SCRATCH_RST;
        end
        else if (done && cfg_sel_q && wr_s)
        begin
            if (a_s[5:0] == `MDA_OFS_OFFSET)
                offset_q <= d_s;
            else if (a_s[5:0] == `MDA_OFS_STATCTL)
            begin
                mem_en_q <= d_s[`MDA_CTL_MEM_EN] && (SPACE != MDA_SP_A16_ONLY);
                srst_q <= d_s[`MDA_CTL_SRST];
            end
            else if (a_s[5:0] == `MDA_OFS_SCRATCH)
                scratch_q <= d_s;
        end
    end

    // Memory array with byte lanes; ROM and soft reset block writes
    always_ff @(posedge clk_i)
    begin
        if (done && mem_sel_q && wr_s && MEM_KIND != `MDA_KIND_ROM && !srst_q)
        begin
            if (ds1_s)
                mem_q[idx_q][15:8] <= d_s[15:8];
            if (ds0_s)
                mem_q[idx_q][7:0] <= d_s[7:0];
        end
    end

    // Bus drivers, all registered
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            data_o <= 16'h0000;
            data_oe_o <= 1'b0;
            dtack_n_o <= 1'b1;
            dtack_oe_o <= 1'b0;
        end
        else if (done)
        begin
            data_o <= cfg_sel_q ? cfg_rdata : mem_q[idx_q];
            data_oe_o <= !wr_s;
            dtack_n_o <= 1'b0;
            dtack_oe_o <= 1'b1;
        end
        else if (state_q != MDA_ST_ACK || !strobe)
        begin
            data_oe_o <= 1'b0;
            dtack_n_o <= 1'b1;
            dtack_oe_o <= 1'b0;
        end
    end

    // Enable status out
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            mem_en_o <= 1'b0;
        else
            mem_en_o <= mem_en_q;
    end
endmodule

// *** verif/mda_attr_checker.sv ***
// Purpose: Port checker for the attribute register slave
// Assumes: Top module runs with its default parameters
// Notes: Bound to the top module from the bench file
`timescale 1ns/100ps
`include "mda_defines.svh"
module mda_attr_checker (
    // Clock, reset and bus inputs
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] la_i,
    input wire logic [63:0] addr_i,
    input wire logic [5:0] am_i,
    input wire logic as_n_i,
    input wire logic ds0_n_i,
    input wire logic ds1_n_i,
    input wire logic write_n_i,
    // Outputs under watch
    input wire logic [15:0] data_o,
    input wire logic data_oe_o,
    input wire logic dtack_n_o,
    input wire logic dtack_oe_o,
    input wire logic mem_en_o
);
    localparam int MAX_CYC = `MDA_CLASS_MAX_CYC;
    localparam logic [15:0] ATTR = {`MDA_KIND_RAM, 3'h7, 3'h4, 2'h3, `MDA_ATTR_RSV, 4'h0};
    logic [5:0] wait_q;
    logic strobe;
    // Pin-level strobe of a cycle
    assign strobe = !as_n_i && !(ds0_n_i && ds1_n_i);
    // Edges since the strobe went active, saturating
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            wait_q <= 6'h00;
        else if (!strobe)
            wait_q <= 6'h00;
        else if (wait_q != 6'h3F)
            wait_q <= wait_q + 6'h01;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_speed_bound: assert property ($rose(dtack_oe_o) |-> int'(wait_q) <= MAX_CYC)
        else $error("acknowledge later than the speed class");
    a_attr_value: assert property ($rose(data_oe_o) && am_i == `MDA_AM_A16_SUP
        && addr_i[15:0] == {2'h3, la_i, `MDA_OFS_ATTR} |-> data_o == ATTR)
        else $error("attribute word wrong");
    a_ack_low: assert property (dtack_oe_o |-> !dtack_n_o)
        else $error("acknowledge driven high");
    a_data_read: assert property (data_oe_o |-> dtack_oe_o && write_n_i)
        else $error("data driven outside a read answer");
    a_data_hold: assert property (data_oe_o && $past(data_oe_o) |-> $stable(data_o))
        else $error("read data moved while driven");
    a_ack_release: assert property ($rose(as_n_i) |-> ##[1:4] !dtack_oe_o)
        else $error("acknowledge not released");
    a_mem_enabled: assert property ($rose(dtack_oe_o) && am_i == `MDA_AM_A24_SUP |-> mem_en_o)
        else $error("memory answered while disabled");
    a_space_only: assert property (dtack_oe_o |-> !(am_i inside {`MDA_AM_A32_SUP,
        `MDA_AM_A32_USR, `MDA_AM_A64_SGL})) else $error("answered outside its space");
    a_en_reset: assert property ($rose(rst_n_i) |-> !mem_en_o ##1 !mem_en_o)
        else $error("memory enabled after reset");
    // Main scenarios
    cover property ($rose(dtack_oe_o) && !write_n_i);
    cover property ($rose(data_oe_o) && am_i == `MDA_AM_A24_USR);
    cover property (strobe && wait_q == 6'h1E);
endmodule

// *** verif/mda_vme_master.sv ***
// Purpose: Bus master model issuing single D16 cycles
// Assumes: Acknowledge wire has a pull-up
// Notes: Released lines show the inverse of their last value
`timescale 1ns/100ps
module mda_vme_master (
    // Clock
    input wire logic clk_i,
    // Lines driven by the master
    output logic [63:0] addr_o,
    output logic [5:0] am_o,
    output logic as_n_o,
    output logic ds_n_o,
    output logic write_n_o,
    output logic [15:0] data_o,
    // Wire levels seen by the master
    input wire logic dtack_n_i,
    input wire logic [15:0] data_i
);
    // Idle bus at time zero
    initial
    begin
        addr_o = 64'h0;
        am_o = 6'h3F;
        as_n_o = 1'b1;
        ds_n_o = 1'b1;
        write_n_o = 1'b1;
        data_o = 16'h0;
    end
    // One cycle; gives up after 30 edges, holds hold edges after the answer
    task automatic cycle(input logic wr, input logic [5:0] am, input logic [63:0] addr,
        input logic [15:0] wd, input int hold, output logic [15:0] rd, output logic ack,
        output int cyc);
        @(negedge clk_i);
        addr_o = addr;
        am_o = am;
        write_n_o = !wr;
        data_o = wr ? wd : ~data_o;
        as_n_o = 1'b0;
        ds_n_o = 1'b0;
        ack = 1'b0;
        rd = 16'h0;
        for (cyc = 1; cyc <= 30 && !ack; cyc++)
        begin
            @(posedge clk_i);
            if (dtack_n_i === 1'b0)
            begin
                ack = 1'b1;
                rd = data_i;
            end
        end
        cyc = cyc - 1;
        repeat (hold) @(posedge clk_i);
        @(negedge clk_i);
        as_n_o = 1'b1;
        ds_n_o = 1'b1;
        addr_o = ~addr_o;
        am_o = ~am_o;
        data_o = ~data_o;
        repeat (5) @(posedge clk_i);
    endtask
endmodule

// *** verif/mda_attr_regs_tb_top.sv ***
// Purpose: Self-checking bench for the attribute register slave
// Assumes: Default parameters, logical address 05
// Notes: Reset check first, then row table, slow-master and second-reset cases
`timescale 1ns/100ps
`include "mda_defines.svh"
module mda_attr_regs_tb_top;
    import mda_pkg::*;
    typedef struct packed {logic wr; logic [5:0] am; logic [63:0] a; logic [15:0] wd;
        logic ack; logic [15:0] rd;} mda_row_t;
    localparam logic [63:0] CFG = 64'hC140;
    localparam logic [63:0] MEM = 64'h1204;
    localparam logic [15:0] ATTR = {`MDA_KIND_RAM, 3'h7, 3'h4, 2'h3, `MDA_ATTR_RSV, 4'h0};
    localparam logic [5:0] SUP = `MDA_AM_A16_SUP;
    localparam logic [5:0] M24 = `MDA_AM_A24_SUP;
    logic clk_i, rst_n_i, as_n, ds_n, wr_n, data_oe, dtack_n, dtack_oe, mem_en, ack;
    logic [63:0] addr;
    logic [5:0] am;
    logic [15:0] m_data, d_out, bus, rd;
    int mismatches, compares, cycles, cyc;
    mda_row_t rows[$];
    // Wire levels of the shared lines
    assign bus = data_oe ? d_out : m_data;
    mda_attr_regs i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .la_i(8'h05), .addr_i(addr),
        .am_i(am), .as_n_i(as_n), .ds0_n_i(ds_n), .ds1_n_i(ds_n), .write_n_i(wr_n),
        .data_i(bus), .data_o(d_out), .data_oe_o(data_oe), .dtack_n_o(dtack_n),
        .dtack_oe_o(dtack_oe), .mem_en_o(mem_en));
    mda_vme_master i_master (.clk_i(clk_i), .addr_o(addr), .am_o(am), .as_n_o(as_n),
        .ds_n_o(ds_n), .write_n_o(wr_n), .data_o(m_data),
        .dtack_n_i(dtack_oe ? dtack_n : 1'b1), .data_i(bus));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic add(input logic w, input logic [5:0] m, input logic [63:0] a,
        input logic [15:0] wd, input logic k, input logic [15:0] r);
        rows.push_back('{w, m, a, wd, k, r});
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Clock and hang limit
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            final_report();
        end
    end
    initial
    begin
        rst_n_i = 1'b0;
        repeat (6) @(negedge clk_i);
        check({12'h0, dtack_oe, data_oe, mem_en, dtack_n}, 16'h0001);
        rst_n_i = 1'b1;
        repeat (4) @(posedge clk_i);
        $display("test reset done");
        add(0, SUP, CFG | 8, 0, 1, ATTR);
        add(1, SUP, CFG | 8, 0, 1, 0);
        add(0, SUP, CFG | 8, 0, 1, ATTR);
        add(0, SUP, CFG | 0, 0, 1, {2'h1, 2'h0, 12'hABC});
        add(0, SUP, CFG | 4, 0, 1, 16'h7FFE);
        add(1, M24, 64'h4, 16'hA5C3, 0, 0);
        add(1, SUP, CFG | 4, 16'h8000, 1, 0);
        add(0, SUP, CFG | 4, 0, 1, 16'hFFFE);
        add(1, SUP, CFG | 6, 16'h1204, 1, 0);
        add(0, SUP, CFG | 6, 0, 1, 16'h1204);
        add(1, M24, MEM << 8, 16'hA5C3, 1, 0);
        add(1, SUP, CFG | 4, 16'h8001, 1, 0);
        add(0, SUP, CFG | 4, 0, 1, 16'hFFFF);
        add(1, M24, MEM << 8, 16'h1111, 1, 0);
        add(1, SUP, CFG | 4, 16'h8000, 1, 0);
        add(0, `MDA_AM_A24_USR, MEM << 8, 0, 1, 16'hA5C3);
        add(0, M24, 64'h4, 0, 0, 0);
        add(0, `MDA_AM_A32_SUP, MEM << 8, 0, 0, 0);
        add(1, SUP, CFG | 10, 16'h5A3C, 1, 0);
        add(0, SUP, CFG | 10, 0, 1, 16'h5A3C);
        foreach (rows[i])
        begin
            i_master.cycle(rows[i].wr, rows[i].am, rows[i].a, rows[i].wd, 0, rd, ack, cyc);
            check({15'h0, ack}, {15'h0, rows[i].ack});
            if (rows[i].ack && !rows[i].wr)
                check(rd, rows[i].rd);
        end
        check({15'h0, mem_en}, 16'h0001);
        $display("test rows done");
        i_master.cycle(0, M24, MEM << 8, 0, 6, rd, ack, cyc);
        check(rd, 16'hA5C3);
        check({15'h0, cyc <= `MDA_CLASS_MAX_CYC}, 16'h0001);
        $display("test slow master done");
        @(negedge clk_i);
        rst_n_i = 1'b0;
        repeat (3) @(negedge clk_i);
        check({12'h0, dtack_oe, data_oe, mem_en, dtack_n}, 16'h0001);
        rst_n_i = 1'b1;
        repeat (4) @(posedge clk_i);
        i_master.cycle(0, SUP, CFG | 8, 0, 0, rd, ack, cyc);
        check(rd, ATTR);
        i_master.cycle(0, M24, MEM << 8, 0, 0, rd, ack, cyc);
        check({15'h0, ack}, 16'h0000);
        $display("test second reset done");
        final_report();
    end
endmodule
bind mda_attr_regs mda_attr_checker i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .la_i(la_i),
    .addr_i(addr_i), .am_i(am_i), .as_n_i(as_n_i), .ds0_n_i(ds0_n_i), .ds1_n_i(ds1_n_i),
    .write_n_i(write_n_i), .data_o(data_o), .data_oe_o(data_oe_o), .dtack_n_o(dtack_n_o),
    .dtack_oe_o(dtack_oe_o), .mem_en_o(mem_en_o));
